// ### core/hbg_regs.svh
// Register offsets, field positions, reset values and timing figures of the gate drive control block.
// Assumes a 50 MHz pclk and a byte-addressed APB register window with one 32-bit word per register.
`ifndef HBG_REGS_SVH
`define HBG_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBG_CLK_PERIOD_NS    20
`define HBG_DELAY_MAX_NS     200
`define HBG_DELAY_MAX_CYC    ((`HBG_DELAY_MAX_NS) / (`HBG_CLK_PERIOD_NS))
`define HBG_BLANK_STEP_NS    250

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HBG_ADDR_CTRL        12'h000
`define HBG_ADDR_PROT        12'h004
`define HBG_ADDR_DLY_LOW     12'h008
`define HBG_ADDR_DLY_HIGH    12'h00c
`define HBG_ADDR_VDS_CFG     12'h010
`define HBG_ADDR_TRIP        12'h014
`define HBG_ADDR_STATUS      12'h018
`define HBG_ADDR_FLAGS       12'h01c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HBG_CTRL_DRV_EN      0
`define HBG_CTRL_BBM_EN      1
`define HBG_PROT_A_LOW       0
`define HBG_PROT_A_HIGH      1
`define HBG_PROT_B_LOW       2
`define HBG_PROT_B_HIGH      3
`define HBG_DLY_W            4
`define HBG_VDS_BLANK_LSB    0
`define HBG_VDS_EN           4
`define HBG_VDS_PART_LSB     5
`define HBG_VDS_TYPE_LSB     8
`define HBG_VDS_CBC_EN       10
`define HBG_TRIP_LOW_LSB     0
`define HBG_TRIP_HIGH_LSB    4
`define HBG_STAT_GATE_LSB    0
`define HBG_STAT_LPROT       6
`define HBG_STAT_HPROT       7
`define HBG_STAT_HOLD_LSB    8
`define HBG_FLAG_HIGH_LSB    3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define HBG_BLANK_RST        4'hf
`define HBG_TRIP_RST         4'hf
`define HBG_TYPE_ALL_OFF     2'h0
`define HBG_TYPE_RECIRC_LOW  2'h1

`endif

// ### core/hbg_pkg.sv
// Types and shared decoding for the gate drive control block.
// Assumes hbg_regs.svh is on the include path.
`include "hbg_regs.svh"

package hbg_pkg;

	typedef logic [3:0] hbg_nib_t;

	typedef enum logic {
		CBC_RUN  = 1'b0,
		CBC_HOLD = 1'b1
	} hbg_cbc_state_t;

	// Blanking setting n means (n + 1) steps; a least time, so it rounds up to whole cycles.
	function automatic logic [7:0] hbg_blank_cycles(input hbg_nib_t sel);
		int ns;
		ns = (int'(sel) + 1) * `HBG_BLANK_STEP_NS;
		return 8'((ns + `HBG_CLK_PERIOD_NS - 1) / `HBG_CLK_PERIOD_NS);
	endfunction

endpackage

// ### core/hbg_delay_line.sv
// Programmable propagation delay for one gate channel, in whole pclk cycles.
// Assumes the input is synchronous to pclk; settings above the longest delay are clamped.
`timescale 1ns/10ps

module hbg_delay_line
	import hbg_pkg::*;
(
	// Clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// Channel
	input  wire logic     din,
	input  wire hbg_nib_t sel,
	output logic          dout
);

	localparam int DEPTH = `HBG_DELAY_MAX_CYC;

	logic [DEPTH-1:0] tap_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_reg <= '0;
		end else begin
			tap_reg <= {tap_reg[DEPTH-2:0], din};
		end
	end

	always_comb begin
		if (sel == 4'h0) begin
			dout = din;
		end else if (int'(sel) >= DEPTH) begin
			dout = tap_reg[DEPTH-1];
		end else begin
			dout = tap_reg[sel - 4'h1];
		end
	end

endmodule

// ### core/hbg_vds_filter.sv
// Blanking filter for one drain-source comparator.
// Assumes the comparator output is synchronous to pclk.
`timescale 1ns/10ps

module hbg_vds_filter
	import hbg_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Qualifiers
	input  wire logic       enable,
	input  wire logic       conducting,
	input  wire logic       over,
	input  wire logic [7:0] limit,
	// Result
	output logic            fault
);

	logic [7:0] cnt_reg;
	logic       active;

	assign active = enable & conducting & over;

	// A fault needs the condition to last longer than the blanking count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else if (!active) begin
			cnt_reg <= 8'h00;
		end else if (cnt_reg <= limit) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	assign fault = active & (cnt_reg > limit);

endmodule

// ### core/hbg_top.sv
// Gate drive control: six gate channels in three phases, APB registers, protection and drain sensing.
// Assumes all pin inputs are synchronous to pclk and the analog comparators report over-threshold levels.
//
// Function
// - Gates follow PWM only with global enable
// - Interlock keeps phase pair never both on
// - High-side protect forces channels 3-5 off
// - Low-side protect forces channels 0-2 off
// - Protect input A routed by two enables
// - Protect input B routed by two enables
// - Low channels 0-2 driven from port bits 0-2
// - High channels 3-5 from port bits 4-6
// - Per-channel delay, zero to 200 ns
// - Fault when conducting switch exceeds trip level
// - Drain sensing only while enabled
// - Fault only beyond blanking time of one to sixteen steps
// - Separate low and high trip levels
// - Drain fault may trigger cycle shutdown
// - Shutdown turns high side off, may recirculate
// - Participation bit set lets phase shut down
// - Type 00 all off, 01 low recirculates
// - Shutdown holds until next PWM rising edge
`timescale 1ns/10ps

module hbg_top
	import hbg_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// PWM port inputs
	input  wire logic        port_b_bit_0,
	input  wire logic        port_b_bit_1,
	input  wire logic        port_b_bit_2,
	input  wire logic        port_b_bit_4,
	input  wire logic        port_b_bit_5,
	input  wire logic        port_b_bit_6,
	// Protection inputs
	input  wire logic        protect_input_a,
	input  wire logic        protect_input_b,
	// Drain-source comparators, one bit per phase
	input  wire logic [2:0]  drain_over_low,
	input  wire logic [2:0]  drain_over_high,
	// Gate outputs
	output logic             low_gate_0,
	output logic             low_gate_1,
	output logic             low_gate_2,
	output logic             high_gate_3,
	output logic             high_gate_4,
	output logic             high_gate_5,
	// Analog settings and protection state
	output logic [3:0]       low_side_trip_level,
	output logic [3:0]       high_side_trip_level,
	output logic             low_side_protect,
	output logic             high_side_protect
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic           driver_global_enable_reg;
	logic           interlock_enable_reg;
	logic [3:0]     prot_cfg_reg;
	hbg_nib_t       delay_sel_reg [6];
	hbg_nib_t       drain_sense_blanking_reg;
	logic           drain_sense_enable_reg;
	logic [2:0]     cycle_participate_reg;
	logic [1:0]     cycle_shutdown_type_reg;
	logic           cycle_shutdown_enable_reg;
	hbg_nib_t       low_trip_reg;
	hbg_nib_t       high_trip_reg;
	logic [5:0]     fault_flag_reg;
	logic [5:0]     gate_reg;
	logic           lprot_reg;
	logic           hprot_reg;
	hbg_cbc_state_t cbc_state_reg [3];
	logic [2:0]     pwm_prev_reg;
	logic [31:0]    prdata_reg;
	logic           pready_reg;
	logic           pslverr_reg;

	logic [5:0]     pwm_in;
	logic [5:0]     pwm_dly;
	logic [5:0]     gate_next;
	logic [2:0]     vds_fault_low;
	logic [2:0]     vds_fault_high;
	logic [7:0]     blank_limit;
	logic           low_prot;
	logic           high_prot;
	logic           wr_en;
	logic           setup;
	logic           mapped;
	logic [31:0]    rd_word;

	// ----------------------------------------------------------------
	// APB access
	// ----------------------------------------------------------------
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready_reg;

	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		case (paddr)
			`HBG_ADDR_CTRL: begin
				rd_word[`HBG_CTRL_DRV_EN] = driver_global_enable_reg;
				rd_word[`HBG_CTRL_BBM_EN] = interlock_enable_reg;
			end
			`HBG_ADDR_PROT: begin
				rd_word[3:0] = prot_cfg_reg;
			end
			`HBG_ADDR_DLY_LOW: begin
				rd_word[11:0] = {delay_sel_reg[2], delay_sel_reg[1], delay_sel_reg[0]};
			end
			`HBG_ADDR_DLY_HIGH: begin
				rd_word[11:0] = {delay_sel_reg[5], delay_sel_reg[4], delay_sel_reg[3]};
			end
			`HBG_ADDR_VDS_CFG: begin
				rd_word[`HBG_VDS_BLANK_LSB +: 4] = drain_sense_blanking_reg;
				rd_word[`HBG_VDS_EN]             = drain_sense_enable_reg;
				rd_word[`HBG_VDS_PART_LSB +: 3]  = cycle_participate_reg;
				rd_word[`HBG_VDS_TYPE_LSB +: 2]  = cycle_shutdown_type_reg;
				rd_word[`HBG_VDS_CBC_EN]         = cycle_shutdown_enable_reg;
			end
			`HBG_ADDR_TRIP: begin
				rd_word[`HBG_TRIP_LOW_LSB +: 4]  = low_trip_reg;
				rd_word[`HBG_TRIP_HIGH_LSB +: 4] = high_trip_reg;
			end
			`HBG_ADDR_STATUS: begin
				rd_word[`HBG_STAT_GATE_LSB +: 6] = gate_reg;
				rd_word[`HBG_STAT_LPROT]         = lprot_reg;
				rd_word[`HBG_STAT_HPROT]         = hprot_reg;
				for (int p = 0; p < 3; p++) begin
					rd_word[`HBG_STAT_HOLD_LSB + p] = (cbc_state_reg[p] == CBC_HOLD);
				end
			end
			`HBG_ADDR_FLAGS: begin
				rd_word[5:0] = fault_flag_reg;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Read data and error are settled in the setup cycle, so the access phase needs no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			pready_reg  <= 1'b0;
		end else begin
			pready_reg <= 1'b1;
			if (setup) begin
				prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
				pslverr_reg <= ~mapped;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			driver_global_enable_reg <= 1'b0;
			interlock_enable_reg     <= 1'b0;
			prot_cfg_reg             <= 4'h0;
		end else if (wr_en && paddr == `HBG_ADDR_CTRL) begin
			driver_global_enable_reg <= pwdata[`HBG_CTRL_DRV_EN];
			interlock_enable_reg     <= pwdata[`HBG_CTRL_BBM_EN];
		end else if (wr_en && paddr == `HBG_ADDR_PROT) begin
			prot_cfg_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 6; c++) begin
				delay_sel_reg[c] <= 4'h0;
			end
		end else if (wr_en && paddr == `HBG_ADDR_DLY_LOW) begin
			for (int c = 0; c < 3; c++) begin
				delay_sel_reg[c] <= pwdata[c*`HBG_DLY_W +: 4];
			end
		end else if (wr_en && paddr == `HBG_ADDR_DLY_HIGH) begin
			for (int c = 0; c < 3; c++) begin
				delay_sel_reg[c+3] <= pwdata[c*`HBG_DLY_W +: 4];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drain_sense_blanking_reg  <= `HBG_BLANK_RST;
			drain_sense_enable_reg    <= 1'b0;
			cycle_participate_reg     <= 3'h0;
			cycle_shutdown_type_reg   <= `HBG_TYPE_ALL_OFF;
			cycle_shutdown_enable_reg <= 1'b0;
			low_trip_reg              <= `HBG_TRIP_RST;
			high_trip_reg             <= `HBG_TRIP_RST;
		end else if (wr_en && paddr == `HBG_ADDR_VDS_CFG) begin
			drain_sense_blanking_reg  <= pwdata[`HBG_VDS_BLANK_LSB +: 4];
			drain_sense_enable_reg    <= pwdata[`HBG_VDS_EN];
			cycle_participate_reg     <= pwdata[`HBG_VDS_PART_LSB +: 3];
			cycle_shutdown_type_reg   <= pwdata[`HBG_VDS_TYPE_LSB +: 2];
			cycle_shutdown_enable_reg <= pwdata[`HBG_VDS_CBC_EN];
		end else if (wr_en && paddr == `HBG_ADDR_TRIP) begin
			low_trip_reg  <= pwdata[`HBG_TRIP_LOW_LSB +: 4];
			high_trip_reg <= pwdata[`HBG_TRIP_HIGH_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------
	// Channel inputs and delays
	// ----------------------------------------------------------------
	assign pwm_in[2:0] = {port_b_bit_2, port_b_bit_1, port_b_bit_0};
	assign pwm_in[5:3] = {port_b_bit_6, port_b_bit_5, port_b_bit_4};

	generate
		for (genvar c = 0; c < 6; c++) begin : g_chan
			hbg_delay_line u_delay (
				.pclk    (pclk),
				.presetn (presetn),
				.din     (pwm_in[c]),
				.sel     (delay_sel_reg[c]),
				.dout    (pwm_dly[c])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Protection routing
	// ----------------------------------------------------------------
	assign low_prot  = (protect_input_a & prot_cfg_reg[`HBG_PROT_A_LOW])
	                 | (protect_input_b & prot_cfg_reg[`HBG_PROT_B_LOW]);
	assign high_prot = (protect_input_a & prot_cfg_reg[`HBG_PROT_A_HIGH])
	                 | (protect_input_b & prot_cfg_reg[`HBG_PROT_B_HIGH]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lprot_reg <= 1'b0;
			hprot_reg <= 1'b0;
		end else begin
			lprot_reg <= low_prot;
			hprot_reg <= high_prot;
		end
	end

	// ----------------------------------------------------------------
	// Drain-source sensing
	// ----------------------------------------------------------------
	assign blank_limit = hbg_blank_cycles(drain_sense_blanking_reg);

	// Only a switch whose gate is on is judged, since an off switch always shows full voltage.
	generate
		for (genvar p = 0; p < 3; p++) begin : g_vds
			hbg_vds_filter u_low (
				.pclk       (pclk),
				.presetn    (presetn),
				.enable     (drain_sense_enable_reg),
				.conducting (gate_reg[p]),
				.over       (drain_over_low[p]),
				.limit      (blank_limit),
				.fault      (vds_fault_low[p])
			);
			hbg_vds_filter u_high (
				.pclk       (pclk),
				.presetn    (presetn),
				.enable     (drain_sense_enable_reg),
				.conducting (gate_reg[p+3]),
				.over       (drain_over_high[p]),
				.limit      (blank_limit),
				.fault      (vds_fault_high[p])
			);
		end
	endgenerate

	// Sticky fault flags, cleared by writing one; a new fault wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_flag_reg <= 6'h00;
		end else begin
			fault_flag_reg <= (fault_flag_reg & ~((wr_en && paddr == `HBG_ADDR_FLAGS) ? pwdata[5:0] : 6'h00))
			                | {vds_fault_high, vds_fault_low};
		end
	end

	// ----------------------------------------------------------------
	// Cycle-by-cycle shutdown, one state machine per phase
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_prev_reg <= 3'h0;
		end else begin
			pwm_prev_reg <= pwm_dly[5:3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < 3; p++) begin
				cbc_state_reg[p] <= CBC_RUN;
			end
		end else begin
			for (int p = 0; p < 3; p++) begin
				case (cbc_state_reg[p])
					CBC_RUN: begin
						if (cycle_shutdown_enable_reg && cycle_participate_reg[p]
						    && (vds_fault_low[p] || vds_fault_high[p])) begin
							cbc_state_reg[p] <= CBC_HOLD;
						end
					end
					CBC_HOLD: begin
						// A fault in the same cycle as the new edge keeps the hold.
						if (pwm_dly[p+3] && !pwm_prev_reg[p]
						    && !(vds_fault_low[p] || vds_fault_high[p])) begin
							cbc_state_reg[p] <= CBC_RUN;
						end
					end
					default: begin
						cbc_state_reg[p] <= CBC_RUN;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Gate resolution
	// ----------------------------------------------------------------
	always_comb begin
		logic lo_req;
		logic hi_req;
		lo_req    = 1'b0;
		hi_req    = 1'b0;
		gate_next = 6'h00;
		for (int p = 0; p < 3; p++) begin
			lo_req = driver_global_enable_reg & ~low_prot & pwm_dly[p];
			hi_req = driver_global_enable_reg & ~high_prot & pwm_dly[p+3];
			if (cbc_state_reg[p] == CBC_HOLD) begin
				hi_req = 1'b0;
				// Reserved type codes fall back to all switches off.
				lo_req = (cycle_shutdown_type_reg == `HBG_TYPE_RECIRC_LOW)
				       & driver_global_enable_reg & ~low_prot;
			end
			// Break before make: a side turns on only once the other side is off at the pin.
			gate_next[p]   = lo_req & ~(interlock_enable_reg & (hi_req | gate_reg[p+3]));
			gate_next[p+3] = hi_req & ~(interlock_enable_reg & (lo_req | gate_reg[p]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_reg <= 6'h00;
		end else begin
			gate_reg <= gate_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign low_gate_0           = gate_reg[0];
	assign low_gate_1           = gate_reg[1];
	assign low_gate_2           = gate_reg[2];
	assign high_gate_3          = gate_reg[3];
	assign high_gate_4          = gate_reg[4];
	assign high_gate_5          = gate_reg[5];
	assign low_side_trip_level  = low_trip_reg;
	assign high_side_trip_level = high_trip_reg;
	assign low_side_protect     = lprot_reg;
	assign high_side_protect    = hprot_reg;
	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;

endmodule

// ### tb/hbg_pwm_model.sv
// Partner model: timer port pins and the six power switches with their drain comparators.
// Assumes the bench sets pin levels and switch load right after a rising pclk edge.
`timescale 1ns/10ps

module hbg_pwm_model (
	// Bench control
	input wire logic [5:0]	lvl,
	input wire logic [2:0]	load_lo,
	input wire logic [2:0]	load_hi,
	// Gates from the block
	input wire logic [5:0]	gate,
	// Pins to the block
	output logic [5:0]	port,
	output logic [2:0]	over_lo,
	output logic [2:0]	over_hi
);
	assign port = lvl;
	// An open switch stands off the supply, so its comparator reads over the trip level.
	assign over_lo = ~gate[2:0] | load_lo;
	assign over_hi = ~gate[5:3] | load_hi;
endmodule

// ### tb/hbg_checker.sv
// Concurrent checks on the gate drive control ports.
// Assumes APB writes land at the edge where psel, penable, pwrite and pready are high.
`timescale 1ns/10ps
`include "hbg_regs.svh"

module hbg_checker (
	// Clock, reset and APB
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pready,
	// Pins
	input wire logic	port_b_bit_0,
	input wire logic	port_b_bit_4,
	input wire logic	protect_input_a,
	input wire logic	protect_input_b,
	input wire logic	low_gate_0,
	input wire logic	low_gate_1,
	input wire logic	low_gate_2,
	input wire logic	high_gate_3,
	input wire logic	high_gate_4,
	input wire logic	high_gate_5,
	input wire logic	low_side_protect,
	input wire logic	high_side_protect
);
	logic [1:0]	ctrl_sh;
	logic [3:0]	prot_sh;
	logic [7:0]	since0;
	logic [7:0]	since4;
	wire		wr = psel && penable && pwrite && pready;
	wire		rt_lo = prot_sh[0] && protect_input_a || prot_sh[2] && protect_input_b;
	wire		rt_hi = prot_sh[1] && protect_input_a || prot_sh[3] && protect_input_b;
	wire [5:0]	g = {high_gate_5, high_gate_4, high_gate_3, low_gate_2, low_gate_1, low_gate_0};

	// Shadows of the control and routing registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_sh <= 2'h0;
			prot_sh <= 4'h0;
		end else if (wr && paddr == `HBG_ADDR_CTRL) begin
			ctrl_sh <= pwdata[1:0];
		end else if (wr && paddr == `HBG_ADDR_PROT) begin
			prot_sh <= pwdata[3:0];
		end
	end

	// Cycles since the watched port bits were last high, saturating.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since0 <= 8'hff;
			since4 <= 8'hff;
		end else begin
			since0 <= port_b_bit_0 ? 8'h00 : since0 + {7'h0, since0 != 8'hff};
			since4 <= port_b_bit_4 ? 8'h00 : since4 + {7'h0, since4 != 8'hff};
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_drive_off: assert property (!$past(ctrl_sh[0]) |-> g == 6'h00)
		else $error("gate on while drivers disabled");
	chk_pair_apart: assert property ($past(ctrl_sh[1]) |-> !(g[0] && g[3]) && !(g[1] && g[4]) && !(g[2] && g[5]))
		else $error("both gates of a phase on");
	chk_low_route: assert property (low_side_protect == $past(rt_lo))
		else $error("low protect routing wrong");
	chk_high_route: assert property (high_side_protect == $past(rt_hi))
		else $error("high protect routing wrong");
	chk_low_prot_off: assert property (low_side_protect |-> g[2:0] == 3'h0)
		else $error("low gate on under protection");
	chk_high_prot_off: assert property (high_side_protect |-> g[5:3] == 3'h0)
		else $error("high gate on under protection");
	chk_low0_source: assert property ($rose(low_gate_0) |-> since0 <= 8'd10)
		else $error("low gate 0 rose without its port bit");
	chk_high3_source: assert property ($rose(high_gate_3) |-> since4 <= 8'd10)
		else $error("high gate 3 rose without its port bit");
endmodule

bind hbg_top hbg_checker hbg_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .port_b_bit_0(port_b_bit_0),
	.port_b_bit_4(port_b_bit_4), .protect_input_a(protect_input_a), .protect_input_b(protect_input_b),
	.low_gate_0(low_gate_0), .low_gate_1(low_gate_1), .low_gate_2(low_gate_2),
	.high_gate_3(high_gate_3), .high_gate_4(high_gate_4), .high_gate_5(high_gate_5),
	.low_side_protect(low_side_protect), .high_side_protect(high_side_protect)
);

// ### tb/hbg_top_tb_top.sv
// Self-checking bench for the gate drive control block.
// Assumes hbg_top, hbg_pwm_model and the bound checker are compiled before it.
`timescale 1ns/10ps
`include "hbg_regs.svh"

module hbg_top_tb_top;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	rdata;
	logic		rerr;
	logic		pa = 1'b0;
	logic		pb = 1'b0;
	logic [5:0]	lvl = 6'h00;
	logic [2:0]	load_hi = 3'h0;
	logic [2:0]	load_lo = 3'h0;
	wire logic [31:0]	prdata;
	wire logic	pready, pslverr, lprot, hprot;
	wire logic [5:0]	port, g;
	wire logic [2:0]	dlo, dhi;
	wire logic [3:0]	ltrip, htrip;
	int		bad_count = 0;
	int		n_compared = 0;
	int		cyc_cnt = 0;

	always #10 pclk = ~pclk;

	hbg_top hbg_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.port_b_bit_0(port[0]), .port_b_bit_1(port[1]), .port_b_bit_2(port[2]),
		.port_b_bit_4(port[3]), .port_b_bit_5(port[4]), .port_b_bit_6(port[5]),
		.protect_input_a(pa), .protect_input_b(pb), .drain_over_low(dlo), .drain_over_high(dhi),
		.low_gate_0(g[0]), .low_gate_1(g[1]), .low_gate_2(g[2]),
		.high_gate_3(g[3]), .high_gate_4(g[4]), .high_gate_5(g[5]),
		.low_side_trip_level(ltrip), .high_side_trip_level(htrip),
		.low_side_protect(lprot), .high_side_protect(hprot)
	);

	hbg_pwm_model hbg_pwm_model_inst (
		.lvl(lvl), .load_lo(load_lo), .load_hi(load_hi), .gate(g),
		.port(port), .over_lo(dlo), .over_hi(dhi)
	);

	task automatic chk(input logic [31:0] e, input logic [31:0] got);
		n_compared++;
		if (got !== e) begin
			$display("mismatch t=%0t exp=%h got=%h", $time, e, got);
			bad_count++;
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(e, rdata);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic drv(input logic [5:0] l);
		@(posedge pclk);
		lvl <= l;
	endtask

	task automatic t_regs();
		rd(`HBG_ADDR_TRIP, 32'hff);
		rd(`HBG_ADDR_VDS_CFG, 32'h0f);
		rd(`HBG_ADDR_CTRL, 32'h0);
		rd(12'h020, 32'h0);
		chk(32'h1, rerr);
		wr(`HBG_ADDR_TRIP, 32'h5a);
		cyc(1);
		chk(32'h5a, {htrip, ltrip});
	endtask

	task automatic t_path();
		drv(6'h3f);
		cyc(3);
		chk(32'h0, g);
		wr(`HBG_ADDR_CTRL, 32'h1);
		for (int i = 0; i < 6; i++) begin
			drv(6'h01 << i);
			cyc(2);
			chk(32'h1 << i, g);
		end
		wr(`HBG_ADDR_CTRL, 32'h3);
		drv(6'h3f);
		cyc(3);
		chk(32'h0, g);
		drv(6'h38);
		cyc(3);
		chk(32'h38, g);
		wr(`HBG_ADDR_CTRL, 32'h1);
	endtask

	task automatic t_delay(input logic [3:0] s);
		int n;
		wr(`HBG_ADDR_DLY_LOW, {20'h0, s, s, s});
		wr(`HBG_ADDR_DLY_HIGH, {20'h0, s, s, s});
		drv(6'h00);
		cyc(12);
		drv(6'h3f);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (g !== 6'h3f && n < 20);
		chk(s + 2, n);
	endtask

	task automatic t_prot();
		logic l, h;
		wr(`HBG_ADDR_DLY_LOW, 32'h0);
		wr(`HBG_ADDR_DLY_HIGH, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(`HBG_ADDR_PROT, 32'h1 << i[1:0]);
			@(posedge pclk);
			pa <= !i[2];
			pb <= i[2];
			cyc(2);
			l = !i[0] && (i[1] == i[2]);
			h = i[0] && (i[1] == i[2]);
			chk({h, l}, {hprot, lprot});
			chk({{3{!h}}, {3{!l}}}, g);
			@(posedge pclk);
			pa <= 1'b0;
			pb <= 1'b0;
		end
		wr(`HBG_ADDR_PROT, 32'h0);
	endtask

	task automatic fault(input int n, input logic hi = 1'b1);
		@(posedge pclk);
		load_hi <= {2'h0, hi};
		load_lo <= {2'h0, !hi};
		repeat (n) @(posedge pclk);
		load_hi <= 3'h0;
		load_lo <= 3'h0;
		cyc(2);
	endtask

	task automatic rearm();
		drv(6'h01);
		cyc(2);
		drv(6'h09);
		cyc(3);
	endtask

	task automatic t_vds();
		drv(6'h09);
		wr(`HBG_ADDR_VDS_CFG, 32'h530);
		fault(12);
		rd(`HBG_ADDR_FLAGS, 32'h0);
		fault(20);
		chk(32'h01, g);
		rd(`HBG_ADDR_FLAGS, 32'h8);
		wr(`HBG_ADDR_FLAGS, 32'h8);
		rd(`HBG_ADDR_FLAGS, 32'h0);
		chk(32'h01, g);
		rd(`HBG_ADDR_STATUS, 32'h101);
		rearm();
		chk(32'h09, g);
		wr(`HBG_ADDR_VDS_CFG, 32'h430);
		fault(20);
		chk(32'h0, g);
		rearm();
		wr(`HBG_ADDR_VDS_CFG, 32'h630);
		fault(20);
		chk(32'h0, g);
		rearm();
		wr(`HBG_ADDR_FLAGS, 32'h8);
		wr(`HBG_ADDR_VDS_CFG, 32'h410);
		fault(20);
		chk(32'h09, g);
		rd(`HBG_ADDR_FLAGS, 32'h8);
		wr(`HBG_ADDR_FLAGS, 32'h8);
		fault(20, 1'b0);
		rd(`HBG_ADDR_FLAGS, 32'h1);
		wr(`HBG_ADDR_FLAGS, 32'h1);
		wr(`HBG_ADDR_VDS_CFG, 32'h420);
		fault(20);
		rd(`HBG_ADDR_FLAGS, 32'h0);
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_path();
		t_delay(4'h0);
		t_delay(4'ha);
		t_prot();
		t_vds();
		results();
	end
endmodule
